// ===== oprc_defs.svh
// constants for the octal psram refresh and configuration block
`ifndef OPRC_DEFS_SVH
`define OPRC_DEFS_SVH
`define OPRC_CFG_OFS       12'h000
`define OPRC_STAT_OFS      12'h004
`define OPRC_CFG_HI_RST    14'h3FF0
`define OPRC_CODE_COOL     2'h1
`define OPRC_CODE_HOT      2'h2
`define OPRC_RSVD_MSB      15
`define OPRC_RSVD_LSB      8
`define OPRC_BURST_BIT     7
`define OPRC_CKTYPE_BIT    6
`define OPRC_SLEEP_BIT     5
`define OPRC_PAR_MSB       4
`define OPRC_PAR_LSB       2
`define OPRC_PAR_NONE      3'h4
`define OPRC_CLK_NS        50
`define OPRC_INT_COOL_NS   4000
`define OPRC_INT_HOT_NS    1000
`define OPRC_INT_COOL_CYC  (`OPRC_INT_COOL_NS / `OPRC_CLK_NS)
`define OPRC_INT_HOT_CYC   (`OPRC_INT_HOT_NS / `OPRC_CLK_NS)
`define OPRC_REF_CYC       3'h4
`define OPRC_CA_LAST       2'h3
`define OPRC_LAT_EDGES     4'h6
`define OPRC_CMD_READ_BIT  7
`define OPRC_CMD_ZLAT_BIT  6
`define OPRC_ADDR_W        6
`define OPRC_MEM_DEPTH     64
`endif

// ===== oprc_pkg.sv
// types shared by the octal psram refresh and configuration block
package oprc_pkg;
  typedef enum logic [5:0] {
    LK_IDLE = 6'h01,
    LK_CA   = 6'h02,
    LK_LAT  = 6'h04,
    LK_RD   = 6'h08,
    LK_WR   = 6'h10,
    LK_WZ   = 6'h20
  } oprc_link_t;
endpackage : oprc_pkg

// ===== oprc_mem_if.sv
// port bundle between the link logic and the byte store
`timescale 1ns/1ps
`include "oprc_defs.svh"
interface oprc_mem_if;
  logic                      we;
  logic [`OPRC_ADDR_W-1:0]   addr;
  logic [7:0]                wdata;
  logic [7:0]                rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface : oprc_mem_if

// ===== oprc_store.sv
// small byte array with registered read data
`timescale 1ns/1ps
`include "oprc_defs.svh"
module oprc_store (
  input wire logic  mclk,
  oprc_mem_if.store mem
);
  logic [7:0] arrayQ [0:`OPRC_MEM_DEPTH-1];
  logic [7:0] rdataQ;

  // no reset on the array: contents are not defined after reset anyway
  always_ff @(posedge mclk) begin
    if (mem.we) begin
      arrayQ[mem.addr] <= mem.wdata;
    end
    rdataQ <= arrayQ[mem.addr];
  end

  assign mem.rdata = rdataQ;
endmodule : oprc_store

// ===== oprc_top.sv
// configuration, self-refresh and pin-state logic of the octal psram device
// Operation
// - reserved upper config byte resets to all ones
// - bit 7 selects burst: one linear (reset), zero wrapped
// - bit 6 selects clock: one single ended (reset), zero differential
// - single ended mode ignores the complement clock input completely
// - bit 5 set enters retention sleep; zero normal, reset value
// - falling select in sleep wakes device and clears bit 5
// - reset also ends sleep; refresh stops during reset
// - bits 4..2 choose refreshed region, full array at reset
// - self-refresh touches only rows in the chosen region
// - bits 1..0 read-only interval code: 01 is 4 us, 10 is 1 us
// - refreshes spread evenly, start only between host accesses
// - refresh pending at access start drives strobe high in address phase
// - read latency: data bus released, strobe driven low
// - write latency: neither data bus nor strobe driven
// - zero-latency write: device holds strobe low, host leaves it
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "oprc_defs.svh"
module oprc_top (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        selectB,
  input  wire logic        linkClk,
  input  wire logic        clockComplement,
  input  wire logic [7:0]  dqIn,
  output logic      [7:0]  dqOut,
  output logic             dqOe,
  input  wire logic        readWriteStrobeIn,
  output logic             readWriteStrobeOut,
  output logic             readWriteStrobeOe,
  input  wire logic        hotTemp,
  output logic             sleepState
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // wrapped bursts stay inside an aligned 16 byte group
  function automatic logic [`OPRC_ADDR_W-1:0] nextAddr(
    input logic [`OPRC_ADDR_W-1:0] a,
    input logic                    linear
  );
    logic [3:0] low;
    low = a[3:0] + 4'h1;
    nextAddr = linear ? a + 6'h01 : {a[5:4], low};
  endfunction : nextAddr

  // map the refresh pointer onto the selected region of eight rows
  function automatic logic [2:0] regionRow(
    input logic [2:0] par,
    input logic [2:0] ptr
  );
    unique case (par)
      3'h0:    regionRow = ptr;
      3'h1:    regionRow = {1'b0, ptr[1:0]};
      3'h2:    regionRow = {2'b00, ptr[0]};
      3'h3:    regionRow = 3'h0;
      3'h5:    regionRow = {1'b1, ptr[1:0]};
      3'h6:    regionRow = {2'b11, ptr[0]};
      default: regionRow = 3'h0;
    endcase
  endfunction : regionRow

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int SW = 13;
  logic [SW-1:0] syncA_q;
  logic [SW-1:0] syncB_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= 13'h0001;
      syncB_q <= 13'h0001;
    end else begin
      syncA_q <= {hotTemp, readWriteStrobeIn, dqIn, clockComplement, linkClk, selectB};
      syncB_q <= syncA_q;
    end
  end

  wire       csLow     = ~syncB_q[0];
  wire       ckS       = syncB_q[1];
  wire       ckbS      = syncB_q[2];
  wire [7:0] dqS       = syncB_q[10:3];
  wire       strobeS   = syncB_q[11];
  wire       hotS      = syncB_q[12];

  //////////////////////////////////////////////////////////////////////////////
  // configuration register and apb slave

  logic [13:0] cfgHi_q;
  logic [13:0] cfgHi_d;
  logic [1:0]  code_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] status;

  wire [15:0] cfgWord   = {cfgHi_q, code_q};
  wire        burstLin  = cfgWord[`OPRC_BURST_BIT];
  wire        ckSingle  = cfgWord[`OPRC_CKTYPE_BIT];
  wire        sleeping  = cfgWord[`OPRC_SLEEP_BIT];
  wire [2:0]  par       = cfgWord[`OPRC_PAR_MSB:`OPRC_PAR_LSB];
  wire        accessCyc = psel & penable & ~pready_q;
  wire        doneCyc   = psel & penable & pready_q;
  wire        hitCfg    = paddr == `OPRC_CFG_OFS;
  wire        hitStat   = paddr == `OPRC_STAT_OFS;
  wire        cfgWrite  = doneCyc & pwrite & hitCfg;
  wire [31:0] readMux   = hitCfg ? {16'h0000, cfgWord} : hitStat ? status : 32'h0000_0000;
  logic       wakeEvt;

  // software write beats the self-clear of the sleep bit in the same cycle
  always_comb begin
    cfgHi_d = cfgHi_q;
    if (wakeEvt) begin
      cfgHi_d[`OPRC_SLEEP_BIT-2] = 1'b0;
    end
    if (cfgWrite) begin
      cfgHi_d = pwdata[15:2];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfgHi_q   <= `OPRC_CFG_HI_RST;
      code_q    <= `OPRC_CODE_COOL;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      cfgHi_q   <= cfgHi_d;
      code_q    <= hotS ? `OPRC_CODE_HOT : `OPRC_CODE_COOL;
      pready_q  <= accessCyc;
      if (accessCyc) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : readMux;
        pslverr_q <= ~(hitCfg | hitStat);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link clock recovery

  logic levelPrev_q;
  logic csPrev_q;

  // the complement input only matters in differential mode
  wire level    = ckSingle ? ckS : (ckS & ~ckbS);
  wire linkEdge = csLow & (level ^ levelPrev_q);
  wire csFall   = csLow & ~csPrev_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      levelPrev_q <= 1'b0;
      csPrev_q    <= 1'b0;
    end else begin
      levelPrev_q <= level;
      csPrev_q    <= csLow;
    end
  end

  assign wakeEvt = csFall & sleeping;

  //////////////////////////////////////////////////////////////////////////////
  // self refresh

  logic [6:0] intCnt_q;
  logic       refPend_q;
  logic       refBusy_q;
  logic [2:0] refCnt_q;
  logic [2:0] refPtr_q;
  logic [2:0] refRow_q;
  oprc_pkg::oprc_link_t state_q;
  oprc_pkg::oprc_link_t state_d;

  // the interval follows the temperature code so rows are spread evenly
  wire [6:0] intLast  = (code_q == `OPRC_CODE_HOT) ?
                        7'(`OPRC_INT_HOT_CYC - 1) : 7'(`OPRC_INT_COOL_CYC - 1);
  wire       intTick  = intCnt_q >= intLast;
  wire       refStart = refPend_q & ~refBusy_q & (state_q == oprc_pkg::LK_IDLE) & ~csLow;
  wire       refDone  = refBusy_q & (refCnt_q == 3'h1);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intCnt_q  <= 7'h00;
      refPend_q <= 1'b0;
      refBusy_q <= 1'b0;
      refCnt_q  <= 3'h0;
      refPtr_q  <= 3'h0;
      refRow_q  <= 3'h0;
    end else begin
      intCnt_q <= intTick ? 7'h00 : intCnt_q + 7'h01;
      if (intTick && par != `OPRC_PAR_NONE) begin
        refPend_q <= 1'b1;
      end else if (refStart) begin
        refPend_q <= 1'b0;
      end
      if (refStart) begin
        refBusy_q <= 1'b1;
        refCnt_q  <= `OPRC_REF_CYC;
        refRow_q  <= regionRow(par, refPtr_q);
      end else if (refDone) begin
        refBusy_q <= 1'b0;
        refPtr_q  <= refPtr_q + 3'h1;
      end else if (refBusy_q) begin
        refCnt_q <= refCnt_q - 3'h1;
      end
    end
  end

  assign status = {19'h00000, refRow_q, refBusy_q, refPend_q, sleeping,
                   ~csLow, state_q};

  //////////////////////////////////////////////////////////////////////////////
  // link state machine

  oprc_mem_if memBus ();

  logic [1:0]              caCnt_q;
  logic [7:0]              cmd_q;
  logic                    extraLat_q;
  logic [3:0]              latCnt_q;
  logic [`OPRC_ADDR_W-1:0] addr_q;
  logic [7:0]              dqOut_q;
  logic                    dqOe_q;
  logic                    strobeOut_q;
  logic                    strobeOe_q;
  logic                    sleepState_q;

  wire caLastEdge = linkEdge & (caCnt_q == `OPRC_CA_LAST);
  wire isRead     = cmd_q[`OPRC_CMD_READ_BIT];
  wire latDone    = linkEdge & (latCnt_q == 4'h1);
  wire wrEdge     = linkEdge & ((state_q == oprc_pkg::LK_WR) | (state_q == oprc_pkg::LK_WZ));
  // address phase strobe follows the latched flag so it always matches the latency count
  wire caStrobe   = (state_q == oprc_pkg::LK_IDLE) ? (refPend_q | refBusy_q) : extraLat_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      oprc_pkg::LK_IDLE: if (csFall && !sleeping) state_d = oprc_pkg::LK_CA;
      oprc_pkg::LK_CA: begin
        if (caLastEdge) begin
          if (isRead) begin
            state_d = oprc_pkg::LK_LAT;
          end else if (cmd_q[`OPRC_CMD_ZLAT_BIT]) begin
            state_d = oprc_pkg::LK_WZ;
          end else begin
            state_d = oprc_pkg::LK_LAT;
          end
        end
      end
      oprc_pkg::LK_LAT: if (latDone) state_d = isRead ? oprc_pkg::LK_RD : oprc_pkg::LK_WR;
      oprc_pkg::LK_RD: state_d = oprc_pkg::LK_RD;
      oprc_pkg::LK_WR: state_d = oprc_pkg::LK_WR;
      oprc_pkg::LK_WZ: state_d = oprc_pkg::LK_WZ;
      default: state_d = oprc_pkg::LK_IDLE;
    endcase
    if (!csLow) begin
      state_d = oprc_pkg::LK_IDLE;
    end
  end

  // pin drive per state; idle covers select high and sleep
  wire       dqOe_d     = (state_d == oprc_pkg::LK_RD);
  wire       strobeOe_d = (state_d == oprc_pkg::LK_CA) |
                          (state_d == oprc_pkg::LK_RD) |
                          (state_d == oprc_pkg::LK_WZ) |
                          ((state_d == oprc_pkg::LK_LAT) & isRead);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= oprc_pkg::LK_IDLE;
      caCnt_q    <= 2'h0;
      cmd_q      <= 8'h00;
      extraLat_q <= 1'b0;
      latCnt_q   <= 4'h0;
      addr_q     <= 6'h00;
    end else begin
      state_q <= state_d;
      if (state_q == oprc_pkg::LK_IDLE) begin
        caCnt_q    <= 2'h0;
        extraLat_q <= refPend_q | refBusy_q;
      end else if (state_q == oprc_pkg::LK_CA && linkEdge) begin
        caCnt_q <= caCnt_q + 2'h1;
        if (caCnt_q == 2'h0) begin
          cmd_q <= dqS;
        end
        if (caLastEdge) begin
          addr_q   <= dqS[`OPRC_ADDR_W-1:0];
          latCnt_q <= extraLat_q ? 4'(`OPRC_LAT_EDGES << 1) : `OPRC_LAT_EDGES;
        end
      end else if (state_q == oprc_pkg::LK_LAT && linkEdge) begin
        latCnt_q <= latCnt_q - 4'h1;
      end
      if ((state_q == oprc_pkg::LK_RD && linkEdge) || wrEdge) begin
        addr_q <= nextAddr(addr_q, burstLin);
      end
    end
  end

  // read bytes come from the store one cycle after the address settles,
  // well inside the gap between two link edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dqOut_q      <= 8'h00;
      dqOe_q       <= 1'b0;
      strobeOut_q  <= 1'b0;
      strobeOe_q   <= 1'b0;
      sleepState_q <= 1'b0;
    end else begin
      dqOe_q       <= dqOe_d;
      strobeOe_q   <= strobeOe_d;
      sleepState_q <= sleeping & ~wakeEvt;
      if (state_d == oprc_pkg::LK_CA) begin
        strobeOut_q <= caStrobe;
      end else if (state_q == oprc_pkg::LK_RD && linkEdge) begin
        strobeOut_q <= ~strobeOut_q;
        dqOut_q     <= memBus.rdata;
      end else if (state_d != oprc_pkg::LK_RD) begin
        strobeOut_q <= 1'b0;
      end
    end
  end

  // strobe high masks the byte in writes that had a latency
  assign memBus.we    = wrEdge & ~((state_q == oprc_pkg::LK_WR) & strobeS);
  assign memBus.addr  = addr_q;
  assign memBus.wdata = dqS;

  oprc_store u_store (
    .mclk (mclk),
    .mem  (memBus.store)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign dqOut              = dqOut_q;
  assign dqOe               = dqOe_q;
  assign readWriteStrobeOut = strobeOut_q;
  assign readWriteStrobeOe  = strobeOe_q;
  assign sleepState         = sleepState_q;

endmodule : oprc_top

// ===== oprc_checker.sv
// concurrent checks on the pins of the octal psram configuration block
`timescale 1ns/1ps
`include "oprc_defs.svh"
module oprc_checker (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        selectB,
  input wire logic [7:0]  dqOut,
  input wire logic        dqOe,
  input wire logic        readWriteStrobeOut,
  input wire logic        readWriteStrobeOe,
  input wire logic        hotTemp,
  input wire logic        sleepState
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic cfgHit = paddr == `OPRC_CFG_OFS;
  wire logic mapHit = cfgHit || paddr == `OPRC_STAT_OFS;
  //////////////////////////////////////////////////////////////////////////////
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  map_refuse_a: assert property (pready && !mapHit |-> pslverr)
    else $error("unmapped access not refused");
  code_read_a: assert property (pready && !pwrite && cfgHit |->
    prdata[1:0] == (hotTemp ? `OPRC_CODE_HOT : `OPRC_CODE_COOL))
    else $error("interval code does not follow temperature");
  sleep_enter_a: assert property (pready && pwrite && cfgHit && pwdata[5] |-> ##[1:4] sleepState)
    else $error("sleep not entered after write");
  sleep_wake_a: assert property (sleepState && $fell(selectB) |-> ##[1:6] !sleepState)
    else $error("falling select did not wake");
  sleep_quiet_a: assert property (sleepState |-> !dqOe && !readWriteStrobeOe)
    else $error("pins driven in sleep");
  idle_release_a: assert property (selectB [*4] |-> !dqOe && !readWriteStrobeOe)
    else $error("pins driven while deselected");
  read_strobe_a: assert property (dqOe |-> readWriteStrobeOe)
    else $error("read data without strobe");
  strobe_toggle_a: assert property (dqOe && $past(dqOe) && $changed(dqOut) |->
    $changed(readWriteStrobeOut))
    else $error("strobe did not toggle with new byte");
endmodule : oprc_checker
//////////////////////////////////////////////////////////////////////////////
bind oprc_top oprc_checker u_oprc_checker (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .selectB, .dqOut, .dqOe, .readWriteStrobeOut,
  .readWriteStrobeOe, .hotTemp, .sleepState);

// ===== oprc_host_model.sv
// host controller model driving the octal link pins
`timescale 1ns/1ps
module oprc_host_model (
  input  wire logic       mclk,
  input  wire logic       diffClk,
  input  wire logic [7:0] dqOut,
  input  wire logic       dqOe,
  input  wire logic       strobeOut,
  input  wire logic       strobeOe,
  output logic            selectB,
  output logic            linkClk,
  output logic            clockComplement,
  output logic      [7:0] dqIn,
  output logic            strobeIn
);
  logic [7:0] hostDq;
  logic [7:0] rd0;
  logic       hostDqOe;
  logic       hostStbOe;
  logic       pat;
  logic       extra;
  logic       bad;
  initial begin
    selectB = 1'b1;
    linkClk = 1'b0;
    hostDq = 8'h00;
    hostDqOe = 1'b0;
    hostStbOe = 1'b0;
    pat = 1'b0;
  end
  always @(posedge mclk) pat <= ~pat;
  // released lines toggle every cycle so a stale level never looks valid
  assign dqIn = dqOe ? dqOut : (hostDqOe ? hostDq : {8{pat}});
  assign strobeIn = strobeOe ? strobeOut : (hostStbOe ? 1'b0 : pat);
  assign clockComplement = diffClk ? ~linkClk : pat;
  //////////////////////////////////////////////////////////////////////////////
  // one link edge every 4 mclk; byte and clock pass the same two-stage sampler,
  // so the byte is settled when the edge is seen; returns once the edge is handled
  task automatic linkEdge(input logic [7:0] b);
    hostDq <= b;
    linkClk <= ~linkClk;
    repeat (4) @(posedge mclk);
  endtask : linkEdge
  // two data bytes, so the edge count stays even and the clock parks low
  task automatic frame(input logic [7:0] cmd, input logic [5:0] addr,
                       input logic [7:0] wd, input int gap);
    int lat;
    @(posedge mclk);
    selectB <= 1'b0;
    hostDqOe <= 1'b1;
    extra = 1'b0;
    bad = 1'b0;
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 4; k++) begin
      linkEdge(k == 0 ? cmd : (k == 3 ? {2'b00, addr} : 8'h00));
      extra |= strobeOe & strobeOut;
    end
    lat = cmd[6] ? 0 : (extra ? 12 : 6);
    if (lat > 0) hostDqOe <= 1'b0;
    // look before each latency edge: the last one already opens the data phase
    for (int k = 0; k < lat; k++) begin
      if (dqOe || (cmd[7] ? (!strobeOe || strobeOut) : strobeOe)) bad = 1'b1;
      linkEdge(8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      hostDqOe <= !cmd[7];
      hostStbOe <= !cmd[7] && !cmd[6];
      linkEdge(wd + 8'(k));
      if (k == 0) rd0 = dqOut;
      if (cmd[7] && !(dqOe && strobeOe)) bad = 1'b1;
    end
    @(posedge mclk);
    selectB <= 1'b1;
    hostDqOe <= 1'b0;
    hostStbOe <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask : frame
  task automatic wake();
    @(posedge mclk);
    selectB <= 1'b0;
    repeat (8) @(posedge mclk);
    selectB <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : wake
endmodule : oprc_host_model

// ===== tb_octal_psram_refresh_config.sv
// self-checking bench for the octal psram configuration block
`timescale 1ns/1ps
`include "oprc_defs.svh"
module tb_octal_psram_refresh_config;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } oprc_row_t;
  logic        mclk, rst_b, psel, penable, pwrite, hotTemp, diffClk, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, s1;
  logic        e, selectB, linkClk, clkComp, stbIn, stbOut, stbOe, dqOe, sleepState;
  logic [7:0]  dqIn, dqOut;
  int          numErrors, nCompared, cycles, extraAny;
  oprc_row_t   rows [8];
  oprc_top u_oprc_top (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .selectB(selectB), .linkClk(linkClk), .clockComplement(clkComp),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .readWriteStrobeIn(stbIn),
    .readWriteStrobeOut(stbOut), .readWriteStrobeOe(stbOe), .hotTemp(hotTemp),
    .sleepState(sleepState));
  oprc_host_model u_oprc_host_model (.mclk(mclk), .diffClk(diffClk), .dqOut(dqOut),
    .dqOe(dqOe), .strobeOut(stbOut), .strobeOe(stbOe), .selectB(selectB),
    .linkClk(linkClk), .clockComplement(clkComp), .dqIn(dqIn), .strobeIn(stbIn));
  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finalReport();
    $display("errors=%0d compared=%0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finalReport
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      numErrors++;
      finalReport();
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, hotTemp, diffClk} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {numErrors, nCompared, cycles, extraAny} = '0;
    rows = '{'{1'b0, 12'h000, 32'h0, 32'h0000FFC1, 1'b0}, '{1'b0, 12'h008, 32'h0, 32'h0, 1'b1},
             '{1'b1, 12'h00C, 32'h0000FF00, 32'h0, 1'b1}, '{1'b1, 12'h000, 32'h0000FF52, 32'h0, 1'b0},
             '{1'b0, 12'h000, 32'h0, 32'h0000FF51, 1'b0}, '{1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1},
             '{1'b1, 12'h000, 32'h0000FF81, 32'h0, 1'b0}, '{1'b0, 12'h000, 32'h0, 32'h0000FF81, 1'b0}};
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(32'(e), 32'(rows[i].e));
      if (!rows[i].wr) chk(q, rows[i].q);
    end
    diffClk <= 1'b1;
    u_oprc_host_model.frame(8'h40, 6'h05, 8'hA5, 8);
    chk(32'(u_oprc_host_model.bad), 32'h0);
    u_oprc_host_model.frame(8'h00, 6'h10, 8'h3C, 8);
    chk(32'(u_oprc_host_model.bad), 32'h0);
    apb(1'b1, `OPRC_CFG_OFS, 32'h0000FFC1);
    diffClk <= 1'b0;
    u_oprc_host_model.frame(8'h80, 6'h10, 8'h00, 8);
    chk(32'(u_oprc_host_model.rd0), 32'h3C);
    chk(32'(u_oprc_host_model.bad), 32'h0);
    // back-to-back reads leave a refresh owed at the next start
    for (int i = 0; i < 3; i++) begin
      u_oprc_host_model.frame(8'h80, 6'h05, 8'h00, 2);
      extraAny |= int'(u_oprc_host_model.extra);
      chk(32'(u_oprc_host_model.rd0), 32'hA5);
    end
    chk(32'(extraAny), 32'h1);
    hotTemp <= 1'b1;
    repeat (5) @(posedge mclk);
    apb(1'b0, `OPRC_CFG_OFS, 32'h0);
    chk(q, 32'h0000FFC2);
    hotTemp <= 1'b0;
    repeat (5) @(posedge mclk);
    apb(1'b1, `OPRC_CFG_OFS, 32'h0000FFD1);
    apb(1'b0, `OPRC_STAT_OFS, 32'h0);
    s1 = q;
    chk(32'(s1[6:0]), 32'h41);
    repeat (300) @(posedge mclk);
    apb(1'b0, `OPRC_STAT_OFS, 32'h0);
    chk(32'(q[12:10]), 32'(s1[12:10]));
    apb(1'b1, `OPRC_CFG_OFS, 32'h0000FFC1);
    repeat (300) @(posedge mclk);
    apb(1'b0, `OPRC_STAT_OFS, 32'h0);
    chk(32'(q[12:10] !== s1[12:10]), 32'h1);
    apb(1'b1, `OPRC_CFG_OFS, 32'h0000FFE1);
    repeat (6) @(posedge mclk);
    chk(32'(sleepState), 32'h1);
    u_oprc_host_model.wake();
    chk(32'(sleepState), 32'h0);
    apb(1'b0, `OPRC_CFG_OFS, 32'h0);
    chk(q, 32'h0000FFC1);
    apb(1'b1, `OPRC_CFG_OFS, 32'h0000FFE1);
    repeat (6) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'({sleepState, dqOe, stbOe}), 32'h0);
    rst_b <= 1'b1;
    apb(1'b0, `OPRC_CFG_OFS, 32'h0);
    chk(q, 32'h0000FFC1);
    finalReport();
  end
endmodule : tb_octal_psram_refresh_config
